// ==== prsc_consts.svh ====
`ifndef PRSC_CONSTS_SVH
`define PRSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define PRSC_ADR_CTRL      11'h000
`define PRSC_ADR_STATUS    11'h004
`define PRSC_ADR_WDC       11'h008
`define PRSC_ADR_IMASK     11'h00C
`define PRSC_RAM_SEL_BIT   10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PRSC_CTRL_CD_LO    0
`define PRSC_CTRL_CD_HI    1
`define PRSC_CTRL_CRYSTAL_AMP_DISABLE    2
`define PRSC_CTRL_RING     3
`define PRSC_CTRL_BGOFF    4
`define PRSC_STAT_RING     0
`define PRSC_STAT_XRDY     1
`define PRSC_STAT_LOW      2
`define PRSC_STAT_WP       3
`define PRSC_STAT_CD_LO    4
`define PRSC_STAT_CD_HI    5
`define PRSC_WDC_XRDY      0
`define PRSC_WDC_POR       6

// ----------------------------------------------------------------------------
// cycle divider codes and reset values
// ----------------------------------------------------------------------------
`define PRSC_CD_RSVD       2'h0
`define PRSC_CD_DIV4       2'h1
`define PRSC_CD_DIV64      2'h2
`define PRSC_CD_DIV1024    2'h3
`define PRSC_MASK_RST      8'h00
`define PRSC_BOOT_VECTOR   16'h0000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PRSC_CLK_HZ        50000000
`define PRSC_POR_DELAY     65536
`define PRSC_XTAL_WARMUP   65536
`define PRSC_CNT_W         17

`endif

// ==== prsc_pkg.sv ====
package prsc_pkg;

  typedef enum logic [1:0] {
    ST_LOW    = 2'b00,
    ST_WARMUP = 2'b01,
    ST_RUN    = 2'b10
  } prsc_state_type;

  typedef struct packed {
    logic        we;
    logic [10:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } prsc_wb_req_type;

  typedef struct packed {
    logic       bgoff;
    logic       ring;
    logic       crystal_amp_disable;
    logic [1:0] cd;
  } prsc_ctrl_type;

endpackage

// ==== prsc_sync.sv ====
`timescale 1ns/100ps
module prsc_sync (
  input  wire logic clk_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o    <= meta_q;
  end

endmodule // prsc_sync

// ==== prsc_cycdiv.sv ====
`timescale 1ns/100ps
`include "prsc_consts.svh"
module prsc_cycdiv (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] cd_i,
  output logic            cyc_en_o,
  output logic            div4_en_o
);

  logic [9:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  // one free counter serves all rates so a rate change never restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_en_o  <= 1'b0;
      div4_en_o <= 1'b0;
    end else begin
      div4_en_o <= &cnt_q[1:0];
      case (cd_i)
        `PRSC_CD_DIV64:   cyc_en_o <= &cnt_q[5:0];
        `PRSC_CD_DIV1024: cyc_en_o <= &cnt_q;
        default:          cyc_en_o <= &cnt_q[1:0];
      endcase
    end
  end

endmodule // prsc_cycdiv

// ==== prsc_top.sv ====
// Notes on behaviour
// RULE1: low supply holds core and I/O reset
// RULE2: low supply drives reset output pin low
// RULE3: low supply blocks every data RAM write
// RULE4: on recovery enable crystal, wait 65536 cycles
// RULE5: then release pin and core, fetch zero
// RULE6: supply reset sets power-on flag, software clears
// RULE7: stop with bandgap off protects, backs RAM
// RULE8: default rate is four clocks per cycle
// RULE9: slow mode runs core at clk/64 or /1024
// RULE10: only software writes select a slow rate
// RULE11: idle halts core, peripherals keep clk/4
// RULE12: ring source selectable, crystal amp may stop
// RULE13: battery-backed data RAM of 256 bytes
// RULE14: divider code 00 reserved, 01/10/11 = 4/64/1024
// RULE15: divider change applies one cycle after write
// RULE16: slow rates only selectable from divide-by-4
// RULE17: crystal re-enable waits 65536 clocks, then ready
// RULE18: supply low asserts async, release is synchronised
`timescale 1ns/100ps
`include "prsc_consts.svh"
module prsc_top #(
  parameter int unsigned POR_DELAY_CYCLES   = `PRSC_POR_DELAY,
  parameter int unsigned XTAL_WARMUP_CYCLES = `PRSC_XTAL_WARMUP
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [10:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        supply_low_i,
  input  wire logic        idle_i,
  input  wire logic        stop_i,
  output logic             core_reset_o,
  output logic             io_reset_o,
  output logic             reset_output_pin_n_o,
  output logic      [15:0] fetch_addr_o,
  output logic             crystal_amp_en_o,
  output logic             ring_select_o,
  output logic             ram_wp_o,
  output logic             battery_backup_o,
  output logic             core_cycle_en_o,
  output logic             periph_cycle_en_o,
  output logic             irq_o
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  prsc_pkg::prsc_wb_req_type req;
  prsc_pkg::prsc_ctrl_type   ctrl_q;
  prsc_pkg::prsc_state_type  state_q;
  logic [`PRSC_CNT_W-1:0]    por_cnt_q;
  logic [`PRSC_CNT_W-1:0]    xtal_cnt_q;
  logic                      low_sync;
  logic                      hold_q;
  logic                      sys_rst;
  logic                      access;
  logic                      wr;
  logic [1:0]                cd_active_q;
  logic                      ring_active_q;
  logic                      xtal_ready_q;
  logic                      xtal_ready_ev;
  logic                      por_ev;
  logic                      por_flag_q;
  logic                      xrdy_flag_q;
  logic [7:0]                mask_q;
  logic [7:0]                wdc;
  logic [7:0]                status;
  logic                      cyc_en;
  logic                      div4_en;
  logic [7:0]                ram_q [256];
  logic [31:0]               rd_d;

  localparam logic [`PRSC_CNT_W-1:0] POR_LAST  = `PRSC_CNT_W'(POR_DELAY_CYCLES - 1);
  localparam logic [`PRSC_CNT_W-1:0] XTAL_LAST = `PRSC_CNT_W'(XTAL_WARMUP_CYCLES - 1);

  assign req     = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
  assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = access & req.we & req.sel[0];
  assign sys_rst = rst_i | core_reset_o;

  // --------------------------------------------------------------------------
  // supply monitor: async hold, synchronised release
  // --------------------------------------------------------------------------
  prsc_sync u_low_sync (
    .clk_i (clk_i),
    .d_i   (supply_low_i),
    .q_o   (low_sync)
  );

  // hold_q catches even a glitch too short for the synchroniser
  always_ff @(posedge clk_i or posedge supply_low_i) begin
    if (supply_low_i) begin
      hold_q               <= 1'b1;                                  // RULE18
      core_reset_o         <= 1'b1;                                  // RULE1
      io_reset_o           <= 1'b1;                                  // RULE1
      reset_output_pin_n_o <= 1'b0;                                  // RULE2
    end else if (rst_i) begin
      hold_q               <= 1'b1;
      core_reset_o         <= 1'b1;
      io_reset_o           <= 1'b1;
      reset_output_pin_n_o <= 1'b0;
    end else begin
      hold_q               <= hold_q & (state_q != prsc_pkg::ST_LOW);
      core_reset_o         <= hold_q | (state_q != prsc_pkg::ST_RUN);  // RULE1
      io_reset_o           <= hold_q | (state_q != prsc_pkg::ST_RUN);  // RULE1
      reset_output_pin_n_o <= ~hold_q & (state_q == prsc_pkg::ST_RUN); // RULE5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= prsc_pkg::ST_LOW;
      por_cnt_q <= '0;
    end else begin
      case (state_q)
        prsc_pkg::ST_LOW: begin
          por_cnt_q <= '0;
          if (!low_sync && !hold_q) begin                            // RULE18
            state_q <= prsc_pkg::ST_WARMUP;
          end
        end
        prsc_pkg::ST_WARMUP: begin
          if (low_sync || hold_q) begin
            state_q <= prsc_pkg::ST_LOW;
          end else if (por_cnt_q == POR_LAST) begin                  // RULE4
            state_q <= prsc_pkg::ST_RUN;
          end else begin
            por_cnt_q <= por_cnt_q + `PRSC_CNT_W'(1);
          end
        end
        prsc_pkg::ST_RUN: begin
          if (low_sync || hold_q) begin
            state_q <= prsc_pkg::ST_LOW;
          end
        end
        default: state_q <= prsc_pkg::ST_LOW;
      endcase
    end
  end

  assign por_ev = (state_q == prsc_pkg::ST_WARMUP) & (por_cnt_q == POR_LAST) & ~low_sync & ~hold_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_addr_o <= `PRSC_BOOT_VECTOR;
    end else if (core_reset_o) begin
      fetch_addr_o <= `PRSC_BOOT_VECTOR;                             // RULE5
    end
  end

  // --------------------------------------------------------------------------
  // clock control register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      ctrl_q <= '{bgoff: 1'b0, ring: 1'b0, crystal_amp_disable: 1'b0, cd: `PRSC_CD_DIV4}; // RULE8
    end else if (wr && req.adr == `PRSC_ADR_CTRL) begin              // RULE10
      ctrl_q.bgoff <= req.dat[`PRSC_CTRL_BGOFF];
      // slow rates only from a settled divide-by-4; reserved code ignored
      if (req.dat[`PRSC_CTRL_CD_HI:`PRSC_CTRL_CD_LO] == `PRSC_CD_DIV4) begin
        ctrl_q.cd <= `PRSC_CD_DIV4;                                  // RULE14
      end else if (req.dat[`PRSC_CTRL_CD_HI] && ctrl_q.cd == `PRSC_CD_DIV4
                   && cd_active_q == `PRSC_CD_DIV4) begin
        ctrl_q.cd <= req.dat[`PRSC_CTRL_CD_HI:`PRSC_CTRL_CD_LO];     // RULE16
      end
      // amp may stop only on ring; back to crystal only once it is ready
      if (!req.dat[`PRSC_CTRL_CRYSTAL_AMP_DISABLE] || ctrl_q.ring) begin
        ctrl_q.crystal_amp_disable <= req.dat[`PRSC_CTRL_CRYSTAL_AMP_DISABLE];                   // RULE12
      end
      if (req.dat[`PRSC_CTRL_RING] || (xtal_ready_q && !ctrl_q.crystal_amp_disable)) begin
        ctrl_q.ring <= req.dat[`PRSC_CTRL_RING];                     // RULE12
      end
    end
  end

  // selections reach the divider on the next instruction cycle boundary
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      cd_active_q   <= `PRSC_CD_DIV4;
      ring_active_q <= 1'b0;
    end else if (cyc_en) begin
      cd_active_q   <= ctrl_q.cd;                                    // RULE15
      ring_active_q <= ctrl_q.ring;
    end
  end

  prsc_cycdiv u_cycdiv (
    .clk_i     (clk_i),
    .rst_i     (sys_rst),
    .cd_i      (cd_active_q),
    .cyc_en_o  (cyc_en),                                             // RULE9
    .div4_en_o (div4_en)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      core_cycle_en_o   <= 1'b0;
      periph_cycle_en_o <= 1'b0;
    end else begin
      core_cycle_en_o   <= cyc_en & ~idle_i & ~stop_i;               // RULE11
      periph_cycle_en_o <= ~stop_i & (idle_i ? div4_en : cyc_en);    // RULE11
    end
  end

  // --------------------------------------------------------------------------
  // crystal amplifier and warm-up
  // --------------------------------------------------------------------------
  // the power-up delay doubles as warm-up, so ready starts out set
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      xtal_cnt_q   <= '0;
      xtal_ready_q <= 1'b1;
    end else if (ctrl_q.crystal_amp_disable) begin
      xtal_cnt_q   <= '0;
      xtal_ready_q <= 1'b0;
    end else if (!xtal_ready_q) begin
      xtal_cnt_q   <= xtal_cnt_q + `PRSC_CNT_W'(1);
      xtal_ready_q <= (xtal_cnt_q == XTAL_LAST);                     // RULE17
    end
  end

  assign xtal_ready_ev = ~sys_rst & ~ctrl_q.crystal_amp_disable & ~xtal_ready_q & (xtal_cnt_q == XTAL_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crystal_amp_en_o <= 1'b1;
      ring_select_o    <= 1'b0;
    end else begin
      crystal_amp_en_o <= core_reset_o | ~ctrl_q.crystal_amp_disable;              // RULE4
      ring_select_o    <= ~core_reset_o & ring_active_q;             // RULE12
    end
  end

  // --------------------------------------------------------------------------
  // battery-backed data RAM
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_wp_o         <= 1'b1;
      battery_backup_o <= 1'b1;
    end else begin
      ram_wp_o         <= hold_q | low_sync | core_reset_o | (stop_i & ctrl_q.bgoff); // RULE3 RULE7
      battery_backup_o <= hold_q | low_sync | (stop_i & ctrl_q.bgoff);                // RULE7
    end
  end

  // no reset on the array: its contents must outlive supply loss
  always_ff @(posedge clk_i) begin
    if (wr && req.adr[`PRSC_RAM_SEL_BIT] && !ram_wp_o && !hold_q && !low_sync) begin // RULE3
      ram_q[req.adr[9:2]] <= req.dat[7:0];                           // RULE13
    end
  end

  // --------------------------------------------------------------------------
  // power-on flag, events, interrupt
  // --------------------------------------------------------------------------
  // a set in the same cycle as a write-one clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_flag_q  <= 1'b0;
      xrdy_flag_q <= 1'b0;
    end else begin
      por_flag_q  <= por_ev | (por_flag_q & ~(wr && req.adr == `PRSC_ADR_WDC
                                              && req.dat[`PRSC_WDC_POR]));   // RULE6
      xrdy_flag_q <= xtal_ready_ev | (xrdy_flag_q & ~(wr && req.adr == `PRSC_ADR_WDC
                                                      && req.dat[`PRSC_WDC_XRDY]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      mask_q <= `PRSC_MASK_RST;
    end else if (wr && req.adr == `PRSC_ADR_IMASK) begin
      mask_q <= req.dat[7:0];
    end
  end

  always_comb begin
    wdc                  = 8'h00;
    wdc[`PRSC_WDC_POR]   = por_flag_q;
    wdc[`PRSC_WDC_XRDY]  = xrdy_flag_q;
    status                   = 8'h00;
    status[`PRSC_STAT_RING]  = ring_active_q;
    status[`PRSC_STAT_XRDY]  = xtal_ready_q;
    status[`PRSC_STAT_LOW]   = low_sync;
    status[`PRSC_STAT_WP]    = ram_wp_o;
    status[`PRSC_STAT_CD_HI:`PRSC_STAT_CD_LO] = cd_active_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(wdc & mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // wishbone slave: ack one cycle after the strobe, unmapped reads zero
  // --------------------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (req.adr[`PRSC_RAM_SEL_BIT]) begin
      rd_d[7:0] = ram_q[req.adr[9:2]];
    end else begin
      case (req.adr)
        `PRSC_ADR_CTRL:   rd_d[4:0] = ctrl_q;
        `PRSC_ADR_STATUS: rd_d[7:0] = status;
        `PRSC_ADR_WDC:    rd_d[7:0] = wdc;
        `PRSC_ADR_IMASK:  rd_d[7:0] = mask_q;
        default:          rd_d      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= (access && !req.we) ? rd_d : 32'h0000_0000;
    end
  end

endmodule // prsc_top

// ==== prsc_top_properties.sv ====
`timescale 1ns/100ps
`include "prsc_consts.svh"
module prsc_top_properties #(
  parameter int unsigned POR_DELAY_CYCLES = `PRSC_POR_DELAY
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        supply_low_i,
  input wire logic        idle_i,
  input wire logic        core_reset_o,
  input wire logic        io_reset_o,
  input wire logic        reset_output_pin_n_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic        ram_wp_o,
  input wire logic        core_cycle_en_o,
  input wire logic        periph_cycle_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------
  // supply-good age, saturating
  // ------------------------------
  logic [10:0] up_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || supply_low_i) begin
      up_q <= 11'h000;
    end else if (up_q != 11'h7FF) begin
      up_q <= up_q + 11'h001;
    end
  end
  sequence s_idle_tick;
    idle_i [*3] ##0 periph_cycle_en_o;
  endsequence
  sequence s_release;
    $fell(core_reset_o);
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  a_low_holds_core: assert property (supply_low_i |-> core_reset_o && io_reset_o)
    else $error("core or io left out of reset while supply low");
  a_low_drives_pin: assert property (supply_low_i |-> !reset_output_pin_n_o)
    else $error("reset pin high while supply low");
  a_low_protects_ram: assert property (supply_low_i [*4] |-> ram_wp_o)
    else $error("data ram writable while supply low");
  a_release_delay: assert property (s_release |-> up_q >= POR_DELAY_CYCLES)
    else $error("reset released before start-up delay");
  a_release_bound: assert property (up_q == POR_DELAY_CYCLES + 8 |-> !core_reset_o)
    else $error("reset still held long after start-up delay");
  a_release_together: assert property (s_release |-> $rose(reset_output_pin_n_o) && !io_reset_o
    && fetch_addr_o == `PRSC_BOOT_VECTOR) else $error("release not joint or bad start address");
  a_cycle_min_gap: assert property (core_cycle_en_o |=> !core_cycle_en_o [*3])
    else $error("instruction cycles closer than four clocks");
  a_idle_periph_rate: assert property (s_idle_tick ##1 idle_i [*4] |-> periph_cycle_en_o)
    else $error("peripheral tick in idle not every four clocks");
  a_idle_core_halt: assert property (idle_i [*2] |-> !core_cycle_en_o)
    else $error("core cycle while idle");
  a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
endmodule // prsc_top_properties

bind prsc_top prsc_top_properties #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .supply_low_i, .idle_i, .core_reset_o,
  .io_reset_o, .reset_output_pin_n_o, .fetch_addr_o, .ram_wp_o, .core_cycle_en_o, .periph_cycle_en_o
);

// ==== prsc_sys_model.sv ====
`timescale 1ns/100ps
// ------------------------------
// external system behind the reset pin
// ------------------------------
module prsc_sys_model (
  input  wire logic        clk_i,
  input  wire logic        reset_output_pin_n_i,
  input  wire logic        core_cycle_en_i,
  input  wire logic        periph_cycle_en_i,
  output logic             sys_held_o,
  output logic      [15:0] core_gap_o,
  output logic      [15:0] periph_gap_o
);
  logic [15:0] core_cnt_q   = 16'h0000;
  logic [15:0] periph_cnt_q = 16'h0000;
  assign sys_held_o = !reset_output_pin_n_i;
  // gap is clocks between the last two ticks
  always_ff @(posedge clk_i) begin
    if (core_cycle_en_i) begin
      core_gap_o <= core_cnt_q;
      core_cnt_q <= 16'h0001;
    end else begin
      core_cnt_q <= core_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (periph_cycle_en_i) begin
      periph_gap_o <= periph_cnt_q;
      periph_cnt_q <= 16'h0001;
    end else begin
      periph_cnt_q <= periph_cnt_q + 16'h0001;
    end
  end
endmodule // prsc_sys_model

// ==== prsc_top_tb.sv ====
`timescale 1ns/100ps
`include "prsc_consts.svh"
module prsc_top_tb;
  localparam int POR = 16;
  localparam int XTW = 16;
  logic        clk_i, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [10:0] wb_adr_i = 11'h000;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic        supply_low_i = 1'b0, idle_i = 1'b0, stop_i = 1'b0;
  logic        wb_ack_o, core_reset_o, io_reset_o, reset_output_pin_n_o, crystal_amp_en_o, ring_select_o;
  logic        ram_wp_o, battery_backup_o, core_cycle_en_o, periph_cycle_en_o, irq_o, sys_held;
  logic [15:0] fetch_addr_o, core_gap, periph_gap;
  logic [1:0]  cd_wr [6] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h1};
  logic [1:0]  cd_exp [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h1};
  logic [15:0] gap_exp [6] = '{16'h0040, 16'h0040, 16'h0004, 16'h0004, 16'h0400, 16'h0004};
  int          n_mismatch = 0, n_tests = 0, n, c;

  prsc_top #(.POR_DELAY_CYCLES(POR), .XTAL_WARMUP_CYCLES(XTW)) DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .supply_low_i, .idle_i, .stop_i, .core_reset_o, .io_reset_o, .reset_output_pin_n_o,
    .fetch_addr_o, .crystal_amp_en_o, .ring_select_o, .ram_wp_o, .battery_backup_o, .core_cycle_en_o,
    .periph_cycle_en_o, .irq_o
  );
  prsc_sys_model u_sys (.clk_i, .reset_output_pin_n_i(reset_output_pin_n_o), .core_cycle_en_i(core_cycle_en_o),
    .periph_cycle_en_i(periph_cycle_en_o), .sys_held_o(sys_held), .core_gap_o(core_gap), .periph_gap_o(periph_gap));

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until ack sampled; released at that same edge
  task automatic wb(input logic w, input logic [10:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wait_rel();
    for (n = 1; n < 200; n++) begin
      @(posedge clk_i);
      if (core_reset_o === 1'b0) break;
    end
    if (n == 200) begin
      n_mismatch++;
      finish_test();
    end
    #1;
  endtask
  task automatic pulses(input bit p, input int k);
    int i;
    int j;
    for (j = 0; j < k; j++) begin
      for (i = 0; i < 3000; i++) begin
        @(posedge clk_i);
        if ((p ? periph_cycle_en_o : core_cycle_en_o) === 1'b1) break;
      end
      if (i == 3000) begin
        n_mismatch++;
        finish_test();
      end
    end
    #1;
  endtask
  // long enough at divide-by-4 for a selection to pass the next instruction cycle and its output flop
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pin_in_reset", reset_output_pin_n_o, 0);
    wait_rel();
    chk("por_len", n >= POR && n <= POR + 8, 1);
    chk("pin_released", reset_output_pin_n_o, 1);
    chk("fetch_addr", fetch_addr_o, `PRSC_BOOT_VECTOR);
    wb(0, `PRSC_ADR_WDC, 0);
    chk("por_flag", rd & 32'h0000_0040, 32'h0000_0040);
    wb(1, `PRSC_ADR_WDC, 32'h0000_0040);
    wb(0, `PRSC_ADR_WDC, 0);
    chk("por_flag_clr", rd & 32'h0000_0040, 0);
    $display("test power_up done");
    wb(1, 11'h400, 32'h0000_00A5);
    wb(1, 11'h7FC, 32'h0000_003C);
    wb(1, 11'h404, 32'h0000_0077);
    wb(0, 11'h7FC, 0);
    chk("ram_top", rd, 32'h0000_003C);
    wb(0, 11'h010, 0);
    chk("unmapped", rd, 0);
    @(posedge clk_i);
    supply_low_i <= 1'b1;
    #1;
    chk("core_rst_low", {core_reset_o, io_reset_o}, 2'b11);
    chk("pin_low", {reset_output_pin_n_o, sys_held}, 2'b01);
    wb(1, 11'h404, 32'h0000_0011);
    settle();
    chk("ram_wp_low", ram_wp_o, 1);
    @(posedge clk_i);
    supply_low_i <= 1'b0;
    wait_rel();
    chk("recover_len", n >= POR && n <= POR + 8, 1);
    wb(0, 11'h404, 0);
    chk("ram_blocked", rd, 32'h0000_0077);
    wb(0, 11'h400, 0);
    chk("ram_kept", rd, 32'h0000_00A5);
    wb(0, `PRSC_ADR_WDC, 0);
    chk("por_flag_again", rd & 32'h0000_0040, 32'h0000_0040);
    chk("irq_masked", irq_o, 0);
    wb(1, `PRSC_ADR_IMASK, 32'h0000_0040);
    settle();
    chk("irq_on", irq_o, 1);
    wb(1, `PRSC_ADR_WDC, 32'h0000_0040);
    settle();
    chk("irq_cleared", irq_o, 0);
    $display("test supply_dip done");
    wb(0, `PRSC_ADR_STATUS, 0);
    chk("cd_default", rd[5:4], `PRSC_CD_DIV4);
    for (int k = 0; k < 6; k++) begin
      wb(1, `PRSC_ADR_CTRL, {30'h0000_0000, cd_wr[k]});
      pulses(0, 3);
      chk("core_gap", core_gap, gap_exp[k]);
      wb(0, `PRSC_ADR_STATUS, 0);
      chk("cd_active", rd[5:4], cd_exp[k]);
    end
    $display("test divider done");
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0002);
    pulses(0, 2);
    @(posedge clk_i);
    idle_i <= 1'b1;
    pulses(1, 3);
    chk("idle_periph", periph_gap, 16'h0004);
    c = 0;
    repeat (80) begin
      @(posedge clk_i);
      c += int'(core_cycle_en_o === 1'b1);
    end
    chk("idle_core", c, 0);
    idle_i <= 1'b0;
    wb(0, `PRSC_ADR_STATUS, 0);
    chk("cd_after_idle", rd[5:4], `PRSC_CD_DIV64);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0011);
    stop_i <= 1'b1;
    settle();
    chk("stop_protect", {ram_wp_o, battery_backup_o}, 2'b11);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0001);
    settle();
    chk("run_writable", {ram_wp_o, battery_backup_o}, 2'b00);
    @(posedge clk_i);
    stop_i <= 1'b0;
    $display("test idle_stop done");
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0005);
    settle();
    chk("crystal_amp_disable_refused", crystal_amp_en_o, 1);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0009);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_000D);
    settle();
    chk("ring_crystal_amp_disable", {ring_select_o, crystal_amp_en_o}, 2'b10);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0009);
    wb(0, `PRSC_ADR_STATUS, 0);
    chk("xtal_not_ready", rd[1], 0);
    repeat (XTW + 4) @(posedge clk_i);
    wb(0, `PRSC_ADR_STATUS, 0);
    chk("xtal_ready", rd[1], 1);
    wb(0, `PRSC_ADR_WDC, 0);
    chk("xtal_event", rd[0], 1);
    wb(1, `PRSC_ADR_CTRL, 32'h0000_0001);
    settle();
    chk("back_to_xtal", ring_select_o, 0);
    $display("test crystal done");
    finish_test();
  end
endmodule // prsc_top_tb
